// *** logic/boot_grant_pkg.sv ***
package boot_grant_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PAGE = 8'h04;
  localparam logic [7:0] OFS_INT_START = 8'h08;
  localparam logic [7:0] OFS_EXT_START = 8'h0C;
  localparam logic [7:0] OFS_WORD_COUNT = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register field positions.
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_CTX_BIT = 1;
  localparam int CTRL_FMT_LSB = 2;
  localparam int CTRL_DIR_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths and values after reset.
  localparam int ADDR_W = 14;
  localparam int PAGE_W = 8;
  localparam logic [13:0] BOOT_WORDS = 14'h0020;
  localparam logic [13:0] COUNT_ZERO = 14'h0000;
  localparam logic [13:0] ADDR_ALL_ON = 14'h3FFF;
  localparam logic [13:0] ADDR_A0_ONLY = 14'h0001;
  localparam logic [1:0] FMT_PM24 = 2'h0;
  localparam logic [7:0] PAGE_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Boot-select patterns, ordered {C, B, A}.
  localparam logic [2:0] MODE_BYTE_FULL = 3'h0;
  localparam logic [2:0] MODE_NO_BOOT = 3'h2;
  localparam logic [2:0] MODE_BYTE_HOST = 3'h4;
  localparam logic [2:0] MODE_HOST_PORT = 3'h5;

  typedef enum logic [1:0] {
    BOOT_WAIT_RELEASE,
    BOOT_BYTE,
    BOOT_HOST_PORT,
    BOOT_RUN
  } boot_state_e;

endpackage

// *** logic/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // A bit changes only once the second and third stages agree.
  always_ff @(posedge clk_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
    level_q <= (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & level_q);
  end

  assign level_o = level_q;

endmodule

`default_nettype wire

// *** logic/bus_arbiter.sv ***
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module bus_arbiter
  import boot_grant_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic request_i,
  input wire logic ext_busy_i,
  input wire logic ext_need_i,
  input wire logic core_ready_i,
  input wire logic go_mode_i,
  input wire logic a0_only_i,
  output logic grant_n_o,
  output logic hang_n_o,
  output logic halt_o,
  output logic drive_en_o,
  output logic [ADDR_W-1:0] addr_en_o
);

  logic grant_d;
  logic stall_d;
  logic grant_n_q;
  logic hang_n_q;
  logic halt_q;
  logic drive_en_q;
  logic [ADDR_W-1:0] addr_en_q;

  // Grant is taken only between external accesses or while in reset, even mid-instruction.
  always_comb begin
    grant_d = request_i & (~grant_n_q | ~ext_busy_i | rst_i);
    stall_d = grant_d & (~go_mode_i | ext_need_i);
  end

  always_ff @(posedge clk_i) begin
    grant_n_q <= ~grant_d;
    halt_q <= stall_d & ~rst_i;
    hang_n_q <= ~(stall_d & core_ready_i & ~rst_i);
  end

  // Memory interface drivers float together with the grant.
  always_ff @(posedge clk_i) begin
    drive_en_q <= ~grant_d;
    if (grant_d) begin
      addr_en_q <= COUNT_ZERO;
    end else if (a0_only_i) begin
      addr_en_q <= ADDR_A0_ONLY;
    end else begin
      addr_en_q <= ADDR_ALL_ON;
    end
  end

  assign grant_n_o = grant_n_q;
  assign hang_n_o = hang_n_q;
  assign halt_o = halt_q;
  assign drive_en_o = drive_en_q;
  assign addr_en_o = addr_en_q;

endmodule

`default_nettype wire

// *** logic/boot_loader_and_bus_grant.sv ***
// Functional notes
// - Boot-select pins are captured as reset releases and choose the boot method.
// - Pattern 000 loads 32 words by byte DMA, holds execution, full memory mode.
// - Pattern 010 boots nothing, runs from external zero, never waits on byte DMA.
// - Pattern 100 does the same 32-word byte boot but in host mode.
// - Pattern 101 boots via host port, holding execution until program word zero written.
// - Byte boot transfer starts as soon as reset is released.
// - Byte boot reset clears direction, page, start addresses; format becomes 24-bit program.
// - Byte boot reset presets the word count to 32.
// - Byte boot sets context reset, holding the core until all words land.
// - After the boot words are loaded, execution begins at address zero.
// - In host mode byte boot drives only address bit zero; outside builds the rest.
// - With no external access running, a request is granted next cycle and halts.
// - While granted, data, address, selects and strobes are all floated.
// - Continue-while-granted keeps executing until an external access is needed.
// - A request during an external access waits until the cycle after it ends.
// - The bus may be granted mid-instruction, even between two external accesses.
// - Dropping the request ends the grant, re-enables drivers and resumes execution.
// - Bus requests are honoured always, during boot and during reset.
// - Grant-hang asserts when ready to execute but stalled by the granted bus.
// - The master frees the bus by dropping request; grant and hang then drop.
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module boot_loader_and_bus_grant
  import boot_grant_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mode_a_i,
  input wire logic mode_b_i,
  input wire logic mode_c_i,
  input wire logic bus_request_in_n_i,
  output logic bus_grant_out_n_o,
  output logic bus_grant_hang_n_o,
  input wire logic ext_busy_i,
  input wire logic ext_need_i,
  input wire logic core_ready_i,
  output logic mem_drive_en_o,
  output logic [ADDR_W-1:0] addr_drive_en_o,
  output logic core_hold_o,
  output logic core_halt_o,
  output logic exec_restart_o,
  output logic host_mode_o,
  input wire logic byte_dma_word_done_i,
  input wire logic host_pm0_written_i,
  output logic byte_dma_start_o,
  output logic byte_dma_direction_o,
  output logic [PAGE_W-1:0] byte_dma_ext_page_o,
  output logic [ADDR_W-1:0] byte_dma_internal_start_o,
  output logic [ADDR_W-1:0] byte_dma_external_start_o,
  output logic [1:0] byte_dma_format_o,
  output logic [ADDR_W-1:0] byte_dma_word_count_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [31:0] merge_w(input logic [31:0] old_w, input logic [31:0] new_w,
                                           input logic [3:0] sel);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic is_byte_boot(input logic [2:0] mode);
    return (mode == MODE_BYTE_FULL) || (mode == MODE_BYTE_HOST);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [2:0] mode_f;
  logic br_n_f;
  logic request;

  pin_sync #(
    .W(3)
  ) u_mode_sync (
    .clk_i(clk_i),
    .pin_i({mode_c_i, mode_b_i, mode_a_i}),
    .level_o(mode_f)
  );

  pin_sync #(
    .W(1)
  ) u_req_sync (
    .clk_i(clk_i),
    .pin_i(bus_request_in_n_i),
    .level_o(br_n_f)
  );

  assign request = ~br_n_f;

  ////////////////////////////////////////////////////////////////////////////////
  // Registers and state.

  boot_state_e state_q;
  logic [2:0] mode_q;
  logic host_mode_q;
  logic go_q;
  logic ctx_q;
  logic dir_q;
  logic [1:0] fmt_q;
  logic [PAGE_W-1:0] page_q;
  logic [ADDR_W-1:0] int_start_q;
  logic [ADDR_W-1:0] ext_start_q;
  logic [ADDR_W-1:0] wc_q;
  logic start_q;
  logic restart_q;
  logic hold_q;
  logic ack_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic [31:0] ctrl_w;
  logic [31:0] wc_w;
  logic [31:0] reg_w;
  logic bus_req;
  logic wr;
  logic count_done;
  logic wc_load;
  logic dma_busy;

  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr = bus_req & wb_we_i & ack_q;
  assign dma_busy = wc_q != COUNT_ZERO;
  assign count_done = byte_dma_word_done_i & (wc_q == ADDR_A0_ONLY);
  assign ctrl_w = merge_w({27'h0, dir_q, fmt_q, ctx_q, go_q}, wb_dat_i, wb_sel_i);
  assign wc_w = merge_w({18'h0, wc_q}, wb_dat_i, wb_sel_i);
  assign reg_w = merge_w(rd_d, wb_dat_i, wb_sel_i);
  assign wc_load = wr && (wb_adr_i == OFS_WORD_COUNT) && (wc_w[ADDR_W-1:0] != COUNT_ZERO);

  ////////////////////////////////////////////////////////////////////////////////
  // Boot-select capture; the last value seen in reset is kept.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= mode_f;
      host_mode_q <= mode_f[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Boot sequencer.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BOOT_WAIT_RELEASE;
    end else begin
      unique case (state_q)
        BOOT_WAIT_RELEASE: begin
          if (is_byte_boot(mode_q)) begin
            state_q <= BOOT_BYTE;
          end else if (mode_q == MODE_HOST_PORT) begin
            state_q <= BOOT_HOST_PORT;
          end else begin
            state_q <= BOOT_RUN;
          end
        end
        BOOT_BYTE: begin
          if (count_done) begin
            state_q <= BOOT_RUN;
          end
        end
        BOOT_HOST_PORT: begin
          if (host_pm0_written_i) begin
            state_q <= BOOT_RUN;
          end
        end
        BOOT_RUN: begin
          state_q <= BOOT_RUN;
        end
      endcase
    end
  end

  // Start pulse at release for a byte boot, or on a nonzero count write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= ((state_q == BOOT_WAIT_RELEASE) && is_byte_boot(mode_q)) || wc_load;
    end
  end

  // Context reset holds the core while words are moving, then restarts at zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_q <= 1'b1;
      restart_q <= 1'b0;
    end else begin
      hold_q <= (state_q != BOOT_RUN) || (ctx_q && dma_busy);
      restart_q <= ctx_q && count_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Byte DMA settings; byte boot defaults are loaded while reset is held.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      go_q <= 1'b0;
      ctx_q <= is_byte_boot(mode_f);
      dir_q <= 1'b0;
      fmt_q <= FMT_PM24;
    end else if (wr && (wb_adr_i == OFS_CTRL)) begin
      go_q <= ctrl_w[CTRL_GO_BIT];
      ctx_q <= ctrl_w[CTRL_CTX_BIT];
      dir_q <= ctrl_w[CTRL_DIR_BIT];
      fmt_q <= ctrl_w[CTRL_FMT_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_q <= PAGE_RESET;
      int_start_q <= COUNT_ZERO;
      ext_start_q <= COUNT_ZERO;
    end else if (wr) begin
      if (wb_adr_i == OFS_PAGE) begin
        page_q <= reg_w[PAGE_W-1:0];
      end
      if (wb_adr_i == OFS_INT_START) begin
        int_start_q <= reg_w[ADDR_W-1:0];
      end
      if (wb_adr_i == OFS_EXT_START) begin
        ext_start_q <= reg_w[ADDR_W-1:0];
      end
    end
  end

  // A write wins over the word-done decrement in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wc_q <= is_byte_boot(mode_f) ? BOOT_WORDS : COUNT_ZERO;
    end else if (wr && (wb_adr_i == OFS_WORD_COUNT)) begin
      wc_q <= wc_w[ADDR_W-1:0];
    end else if (byte_dma_word_done_i && dma_busy) begin
      wc_q <= wc_q - ADDR_A0_ONLY;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus arbiter.

  bus_arbiter u_arbiter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .request_i(request),
    .ext_busy_i(ext_busy_i),
    .ext_need_i(ext_need_i),
    .core_ready_i(core_ready_i),
    .go_mode_i(go_q),
    .a0_only_i(host_mode_q && dma_busy),
    .grant_n_o(bus_grant_out_n_o),
    .hang_n_o(bus_grant_hang_n_o),
    .halt_o(core_halt_o),
    .drive_en_o(mem_drive_en_o),
    .addr_en_o(addr_drive_en_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave; unmapped reads return zero, unmapped writes are dropped.

  always_comb begin
    unique case (wb_adr_i)
      OFS_CTRL: rd_d = {27'h0, dir_q, fmt_q, ctx_q, go_q};
      OFS_PAGE: rd_d = {24'h0, page_q};
      OFS_INT_START: rd_d = {18'h0, int_start_q};
      OFS_EXT_START: rd_d = {18'h0, ext_start_q};
      OFS_WORD_COUNT: rd_d = {18'h0, wc_q};
      OFS_STATUS: rd_d = {24'h0, dma_busy, ~bus_grant_hang_n_o, ~bus_grant_out_n_o,
                          state_q == BOOT_RUN, host_mode_q, mode_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req && !ack_q;
      if (bus_req && !ack_q) begin
        rd_q <= rd_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;
  assign core_hold_o = hold_q;
  assign exec_restart_o = restart_q;
  assign host_mode_o = host_mode_q;
  assign byte_dma_start_o = start_q;
  assign byte_dma_direction_o = dir_q;
  assign byte_dma_ext_page_o = page_q;
  assign byte_dma_internal_start_o = int_start_q;
  assign byte_dma_external_start_o = ext_start_q;
  assign byte_dma_format_o = fmt_q;
  assign byte_dma_word_count_o = wc_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence byte_release_s;
    $past(rst_i) && is_byte_boot(mode_q);
  endsequence

  sequence boot_done_s;
    (state_q == BOOT_BYTE) && count_done && ctx_q;
  endsequence

  mode_capture_a: assert property ($past(!rst_i) |-> $stable(mode_q))
    else $error("boot mode changed after reset release");

  byte_defaults_a: assert property (byte_release_s |-> (wc_q == BOOT_WORDS) &&
    (fmt_q == FMT_PM24) && !dir_q && (page_q == PAGE_RESET) && ctx_q ##1 byte_dma_start_o)
    else $error("byte boot defaults or start missing");

  byte_hold_a: assert property ((state_q == BOOT_BYTE) |-> core_hold_o)
    else $error("core not held during byte boot");

  no_boot_a: assert property ((state_q == BOOT_RUN) && (mode_q == MODE_NO_BOOT) && !ctx_q
    |=> !core_hold_o)
    else $error("core held without boot");

  host_boot_a: assert property ((state_q == BOOT_HOST_PORT) && !host_pm0_written_i
    |=> (state_q == BOOT_HOST_PORT) && core_hold_o)
    else $error("host boot ended early");

  boot_restart_a: assert property (boot_done_s |=> exec_restart_o &&
    (state_q == BOOT_RUN) ##1 !core_hold_o || dma_busy)
    else $error("no restart after boot words");

  grant_answer_a: assert property (request && !ext_busy_i && bus_grant_out_n_o
    |=> !bus_grant_out_n_o && (core_halt_o || go_q))
    else $error("request not granted next cycle");

  grant_float_a: assert property (!bus_grant_out_n_o |-> !mem_drive_en_o &&
    (addr_drive_en_o == COUNT_ZERO))
    else $error("drivers active while granted");

  go_mode_a: assert property (!bus_grant_out_n_o && $past(go_q && !ext_need_i)
    |-> !core_halt_o)
    else $error("halted in continue mode");

  grant_wait_a: assert property (request && ext_busy_i && bus_grant_out_n_o
    |=> bus_grant_out_n_o)
    else $error("granted during external access");

  release_all_a: assert property (!request |=> bus_grant_out_n_o && bus_grant_hang_n_o &&
    mem_drive_en_o && !core_halt_o)
    else $error("bus not returned after request drop");

  hang_cause_a: assert property (!bus_grant_hang_n_o |-> !bus_grant_out_n_o &&
    $past(core_ready_i))
    else $error("hang without grant or ready");

endmodule

`default_nettype wire

// *** verification/bus_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Outside bus master: asks for the bus and drives it only once it is granted.
module bus_master_model (
  input wire logic clk_i,
  input wire logic want_i,
  input wire logic grant_n_i,
  output logic request_n_o,
  output logic driving_o
);
  initial begin
    request_n_o = 1'h1;
    driving_o = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // The request stays low for as long as the model drives the bus.
  always @(posedge clk_i) begin
    driving_o <= want_i && (grant_n_i === 1'h0);
    if (want_i || driving_o) begin
      request_n_o <= 1'h0;
    end else begin
      request_n_o <= 1'h1;
    end
  end
endmodule

`default_nettype wire

// *** verification/boot_loader_and_bus_grant_tb.sv ***
`timescale 1ns/100ps
`default_nettype none

module boot_loader_and_bus_grant_tb
  import boot_grant_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat_w = 32'h0;
  logic [31:0] dat_r, rd, mask;
  logic [31:0] seed = 32'h0CECEE35;
  logic [2:0] mode = 3'h0;
  logic want = 1'h0;
  logic busy = 1'h0;
  logic need = 1'h0;
  logic ready = 1'h0;
  logic done = 1'h0;
  logic pm0 = 1'h0;
  logic ack, req_n, drv, grant_n, hang_n, drive_en, hold, halt, restart, host, start, dir;
  logic [PAGE_W-1:0] page;
  logic [ADDR_W-1:0] addr_en, istart, estart, count;
  logic [1:0] fmt;
  logic [2:0] pats [5] = '{3'h0, 3'h2, 3'h4, 3'h5, 3'h7};
  int bad_count = 0;
  int tests_run = 0;
  int exp_count, n;
  logic [31:0] exp_q [$];

  boot_loader_and_bus_grant boot_loader_and_bus_grant_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .mode_a_i(mode[0]), .mode_b_i(mode[1]), .mode_c_i(mode[2]),
    .bus_request_in_n_i(req_n), .bus_grant_out_n_o(grant_n), .bus_grant_hang_n_o(hang_n),
    .ext_busy_i(busy), .ext_need_i(need), .core_ready_i(ready),
    .mem_drive_en_o(drive_en), .addr_drive_en_o(addr_en), .core_hold_o(hold),
    .core_halt_o(halt), .exec_restart_o(restart), .host_mode_o(host),
    .byte_dma_word_done_i(done), .host_pm0_written_i(pm0), .byte_dma_start_o(start),
    .byte_dma_direction_o(dir), .byte_dma_ext_page_o(page),
    .byte_dma_internal_start_o(istart), .byte_dma_external_start_o(estart),
    .byte_dma_format_o(fmt), .byte_dma_word_count_o(count)
  );

  bus_master_model bus_master_model_inst (
    .clk_i(clk_i), .want_i(want), .grant_n_i(grant_n), .request_n_o(req_n), .driving_o(drv)
  );

  always #50 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  function automatic logic pick(input int w);
    case (w)
      0: return start;
      1: return restart;
      2: return hold;
      3: return grant_n;
      default: return halt;
    endcase
  endfunction

  // Waits, bounded, until the chosen output reaches the level.
  task automatic await_sig(input int w, input logic lvl, input int lim);
    n = 0;
    while (pick(w) !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat_w <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'h1 && k < 20);
    check(ack, 1'h1);
    rd = dat_r;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic do_reset(input logic [2:0] m);
    mode <= m;
    rst_i <= 1'h1;
    repeat (12) @(posedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    @(posedge clk_i);
    foreach (pats[i]) begin
      exp_count = (pats[i] == MODE_BYTE_FULL || pats[i] == MODE_BYTE_HOST) ? 32 : 0;
      do_reset(pats[i]);
      check(count, exp_count);
      check({fmt, dir, page}, 32'h0);
      check({istart, estart}, 32'h0);
      check(hold, 1'h1);
      rst_i <= 1'h0;
      mode <= ~pats[i];
      await_sig(0, 1'h1, 4);
      check(start, exp_count != 0);
      check(host, pats[i][2]);
      wb(OFS_STATUS, 1'h0, 32'h0);
      check(rd[3:0], {pats[i][2], pats[i]});
      if (exp_count != 0) begin
        check(addr_en, pats[i][2] ? ADDR_A0_ONLY : ADDR_ALL_ON);
        repeat (32) begin
          check(hold, 1'h1);
          done <= 1'h1;
          @(posedge clk_i);
          done <= 1'h0;
          exp_count--;
          @(posedge clk_i);
          check(count, exp_count);
        end
        await_sig(1, 1'h1, 4);
        check(restart, 1'h1);
        @(posedge clk_i);
        check(restart, 1'h0);
      end else if (pats[i] == MODE_HOST_PORT) begin
        repeat (8) @(posedge clk_i);
        check(hold, 1'h1);
        pm0 <= 1'h1;
        @(posedge clk_i);
        pm0 <= 1'h0;
      end
      await_sig(2, 1'h0, 4);
      check(hold, 1'h0);
      $display("Boot test for pattern %h finished", pats[i]);
    end
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      mask = (k == 0) ? 32'h000000FF : 32'h00003FFF;
      exp_q.push_back(seed & mask);
      wb(OFS_PAGE + 8'(4 * k), 1'h1, seed);
      wb(OFS_PAGE + 8'(4 * k), 1'h0, 32'h0);
      check(rd, exp_q[k]);
    end
    check(page, exp_q[0]);
    check(istart, exp_q[1]);
    check(estart, exp_q[2]);
    wb(8'h20, 1'h0, 32'h0);
    check(rd, 32'h0);
    wb(OFS_WORD_COUNT, 1'h1, 32'h2);
    check(start, 1'h1);
    check(count, 32'h2);
    @(posedge clk_i);
    check(addr_en, ADDR_A0_ONLY);
    repeat (2) begin
      done <= 1'h1;
      @(posedge clk_i);
    end
    done <= 1'h0;
    @(posedge clk_i);
    check({start, count}, 32'h0);
    $display("Register test finished");
    busy <= 1'h1;
    ready <= 1'h1;
    want <= 1'h1;
    repeat (8) @(posedge clk_i);
    check({grant_n, drive_en}, 2'h3);
    check(drv, 1'h0);
    busy <= 1'h0;
    @(posedge clk_i);
    busy <= 1'h1;
    await_sig(3, 1'h0, 3);
    check(grant_n, 1'h0);
    repeat (2) @(posedge clk_i);
    check({drive_en, addr_en}, 32'h0);
    check({halt, hang_n}, 2'h2);
    check(drv, 1'h1);
    busy <= 1'h0;
    wb(OFS_CTRL, 1'h1, 32'h1);
    await_sig(4, 1'h0, 4);
    check({halt, hang_n}, 2'h1);
    need <= 1'h1;
    @(posedge clk_i);
    await_sig(4, 1'h1, 4);
    check(halt, 1'h1);
    want <= 1'h0;
    await_sig(3, 1'h1, 10);
    check(grant_n, 1'h1);
    repeat (2) @(posedge clk_i);
    check({hang_n, halt, drive_en}, 3'h5);
    check(addr_en, ADDR_ALL_ON);
    $display("Bus grant test finished");
    want <= 1'h1;
    do_reset(MODE_NO_BOOT);
    check({grant_n, drive_en}, 2'h0);
    want <= 1'h0;
    rst_i <= 1'h0;
    await_sig(3, 1'h1, 10);
    check(grant_n, 1'h1);
    $display("Grant during reset test finished");
    complete_run();
  end

  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end
endmodule

`default_nettype wire
